// >>> rtl/csm_card_state.v
`timescale 1ns/1ps
`include "csm_consts.vh"
// Card state, status and sleep control; command line in and out
module csm_card_state #(
  parameter SLEEP_CYC = `CSM_SLEEP_CYC,
  parameter [31:0] OCR_MASK = 32'h00ff8000,
  parameter [7:0] SPEED_CODE = 8'h32,
  parameter [4:0] ERASE_GRP = 5'h1f,
  parameter [4:0] WP_GRP = 5'h03
) (
  // Clock and reset
  input wire clk_i,
  input wire sys_rst_i,
  // Card bus pins
  input wire link_clk_i,
  input wire cmd_i,
  input wire dat0_i,
  output reg cmd_o,
  output reg cmd_oe_n_o,
  // Flash back end
  input wire op_done_i,
  input wire verify_done_i,
  input wire verify_fail_i,
  input wire ecc_fix_i,
  output reg op_req_o,
  output reg op_wr_o,
  output reg [31:0] op_addr_o,
  output reg [15:0] sec_cnt_o,
  output reg [7:0] wr_data_o,
  output reg wr_stb_o,
  output reg verify_req_o,
  output reg remap_req_o,
  output reg spare_sub_o,
  // Card state view
  output reg asleep_o,
  output reg inactive_o,
  output reg [1:0] bus_width_o,
  output reg [31:0] status_o,
  output reg blk_crc_err_o,
  output reg [127:0] card_specific_data_reg_o
);
  localparam SW = $clog2(SLEEP_CYC + 1);
  localparam [SW-1:0] SLEEP_END = SLEEP_CYC;
  localparam [1:0] D_OFF = 2'h0;
  localparam [1:0] D_START = 2'h1;
  localparam [1:0] D_BITS = 2'h2;
  localparam [1:0] D_CRC = 2'h3;

  wire link_lvl;
  wire cmd_lvl;
  wire dat_lvl;
  reg link_q;
  wire link_rise;
  wire link_fall;
  reg rx_busy;
  reg [5:0] rx_cnt;
  reg [47:0] rx_sr;
  reg cmd_done;
  reg [3:0] card_st;
  reg [31:0] flags;
  reg [135:0] rsp_sr;
  reg [7:0] rsp_len;
  reg [3:0] rsp_wait;
  reg no_erase;
  reg verifying;
  reg [1:0] dst;
  reg [12:0] dcnt;
  reg [15:0] dcrc;
  reg [15:0] dcrc_rx;
  reg [SW-1:0] idle_cnt;
  reg data_err;
  wire [5:0] idx;
  wire [31:0] arg;
  wire frame_ok;
  wire [31:0] stat_now;
  reg [31:0] ev;
  reg next_inact;
  reg [3:0] next_st;
  reg [1:0] rsp_kind;
  wire [15:0] dcrc_nx;

  // CRC-7 over the leading n bits of d
  function [6:0] crc7;
    input [119:0] d;
    input [6:0] n;
    integer i;
    reg fb;
    begin
      crc7 = 7'h00;
      for (i = 0; i < 120; i = i + 1) begin
        if (i < n) begin
          fb = d[119 - i] ^ crc7[6];
          crc7 = {crc7[5:0], 1'b0};
          if (fb) begin
            crc7 = crc7 ^ `CSM_CRC7_POLY;
          end
        end
      end
    end
  endfunction

  // Pins cross into the core clock domain
  csm_sync #(.RST_VAL(1'b0)) u_sync_clk (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .async_i(link_clk_i),
    .level_o(link_lvl)
  );
  csm_sync #(.RST_VAL(1'b1)) u_sync_cmd (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .async_i(cmd_i),
    .level_o(cmd_lvl)
  );
  csm_sync #(.RST_VAL(1'b1)) u_sync_dat (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .async_i(dat0_i),
    .level_o(dat_lvl)
  );

  // No minimum bus clock: nothing waits on link edges; max rate is core/5
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      link_q <= 1'b0;
    end else begin
      link_q <= link_lvl;
    end
  end
  assign link_rise = link_lvl & ~link_q;
  assign link_fall = ~link_lvl & link_q;

  assign idx = rx_sr[45:40];
  assign arg = rx_sr[39:8];
  assign frame_ok = (crc7({rx_sr[47:8], 80'h0}, 7'd40) == rx_sr[7:1]) &&
                    rx_sr[46] && rx_sr[0];
  // Current state and pending completion codes
  assign stat_now = flags | {19'h0, card_st, (card_st == `CSM_ST_TRAN), 8'h00};
  assign dcrc_nx = {dcrc[14:0], 1'b0} ^ ((dat_lvl ^ dcrc[15]) ? `CSM_CRC16_POLY : 16'h0000);

  // Command frame receiver, sampled on bus clock rising edges
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      rx_busy <= 1'b0;
      rx_cnt <= 6'h00;
      rx_sr <= 48'h0;
      cmd_done <= 1'b0;
    end else begin
      cmd_done <= 1'b0;
      if (link_rise && !inactive_o && cmd_oe_n_o) begin
        if (rx_busy || !cmd_lvl) begin
          rx_sr <= {rx_sr[46:0], cmd_lvl};
          if (rx_cnt == 6'd47) begin
            rx_busy <= 1'b0;
            rx_cnt <= 6'h00;
            cmd_done <= 1'b1;
          end else begin
            rx_busy <= 1'b1;
            rx_cnt <= rx_cnt + 6'd1;
          end
        end
      end
    end
  end

  // Decode: completion codes and next state of one command
  always @* begin
    ev = 32'h0;
    next_inact = 1'b0;
    next_st = card_st;
    rsp_kind = 2'h1;
    if (!frame_ok) begin
      ev[`CSM_SB_CRC] = 1'b1;
      rsp_kind = 2'h0;
    end else if (idx == `CSM_CMD_RESET) begin
      next_st = `CSM_ST_IDLE;
      rsp_kind = 2'h0;
    end else if (idx == `CSM_CMD_INACT) begin
      next_inact = 1'b1;
      rsp_kind = 2'h0;
    end else if (idx == `CSM_CMD_OPCOND) begin
      if ((arg & OCR_MASK) == 32'h0) begin
        next_inact = 1'b1;
        rsp_kind = 2'h0;
      end else begin
        next_st = `CSM_ST_READY;
        rsp_kind = 2'h2;
      end
    end else if (card_st == `CSM_ST_IDLE) begin
      ev[`CSM_SB_ILL] = 1'b1;
      rsp_kind = 2'h0;
    end else if (idx == `CSM_CMD_STATUS) begin
      rsp_kind = 2'h1;
    end else if (idx == `CSM_CMD_SELECT) begin
      if (card_st == `CSM_ST_READY) begin
        next_st = `CSM_ST_TRAN;
      end
    end else if (idx == `CSM_CMD_RDCSD) begin
      rsp_kind = 2'h3;
    end else if (card_st != `CSM_ST_TRAN) begin
      ev[`CSM_SB_ILL] = 1'b1;
      rsp_kind = 2'h0;
    end else if (idx == `CSM_CMD_SWITCH) begin
      if (arg[15:8] > 8'h02) begin
        ev[`CSM_SB_SWERR] = 1'b1;
      end
    end else if (idx == `CSM_CMD_BLKLEN) begin
      if (arg != `CSM_SECT_BYTES) begin
        ev[`CSM_SB_BLKLEN] = 1'b1;
      end
    end else if (idx == `CSM_CMD_SECCNT) begin
      rsp_kind = 2'h1;
    end else if (idx == `CSM_CMD_RD) begin
      next_st = `CSM_ST_DATA;
    end else if (idx == `CSM_CMD_WR || idx == `CSM_CMD_WRNE) begin
      if (arg[8:0] != 9'h000) begin
        ev[`CSM_SB_OOR] = 1'b1;
      end else begin
        next_st = `CSM_ST_RCV;
      end
    end else begin
      ev[`CSM_SB_ILL] = 1'b1;
      rsp_kind = 2'h0;
    end
  end

  // State, status and response load; a data error set wins over clear-on-send
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      card_st <= `CSM_ST_IDLE;
      inactive_o <= 1'b0;
      flags <= 32'h0;
      bus_width_o <= 2'h0;
      rsp_sr <= {136{1'b1}};
      rsp_len <= 8'h00;
      rsp_wait <= 4'h0;
      op_req_o <= 1'b0;
      op_wr_o <= 1'b0;
      op_addr_o <= 32'h0;
      sec_cnt_o <= 16'h0001;
      no_erase <= 1'b0;
      verifying <= 1'b0;
      verify_req_o <= 1'b0;
      remap_req_o <= 1'b0;
      spare_sub_o <= 1'b0;
      status_o <= 32'h0;
    end else begin
      op_req_o <= 1'b0;
      verify_req_o <= 1'b0;
      remap_req_o <= 1'b0;
      spare_sub_o <= ecc_fix_i;
      status_o <= stat_now;
      if (cmd_done && !inactive_o) begin
        card_st <= next_st;
        inactive_o <= next_inact;
        if (rsp_kind == 2'h0) begin
          flags <= flags | ev;
        end else begin
          flags <= 32'h0;
          rsp_wait <= `CSM_NCR;
        end
        // A data error arriving with a command is kept: set beats clear
        if (data_err) begin
          flags[`CSM_SB_ERR] <= 1'b1;
        end
        // Response carries the codes of the command just handled
        if (rsp_kind == 2'h1) begin
          rsp_sr <= {2'b00, idx, stat_now | ev,
                     crc7({2'b00, idx, stat_now | ev, 80'h0}, 7'd40), 1'b1, 88'h0};
          rsp_len <= 8'd48;
        end else if (rsp_kind == 2'h2) begin
          rsp_sr <= {2'b00, 6'h3f, 1'b1, OCR_MASK[30:0], 7'h7f, 1'b1, 88'h0};
          rsp_len <= 8'd48;
        end else if (rsp_kind == 2'h3) begin
          rsp_sr <= {2'b00, 6'h3f, card_specific_data_reg_o[127:8],
                     crc7(card_specific_data_reg_o[127:8], 7'd120), 1'b1};
          rsp_len <= 8'd136;
        end
        if (frame_ok && card_st == `CSM_ST_TRAN && ev == 32'h0) begin
          if (idx == `CSM_CMD_SWITCH) begin
            bus_width_o <= arg[9:8];
          end
          if (idx == `CSM_CMD_SECCNT) begin
            sec_cnt_o <= arg[15:0];
          end
          if (idx == `CSM_CMD_RD) begin
            op_req_o <= 1'b1;
            op_wr_o <= 1'b0;
            op_addr_o <= arg;
          end
          if (idx == `CSM_CMD_WR || idx == `CSM_CMD_WRNE) begin
            op_addr_o <= arg;
            no_erase <= (idx == `CSM_CMD_WRNE);
          end
        end
      end else begin
        if (data_err) begin
          flags[`CSM_SB_ERR] <= 1'b1;
        end
        if (link_fall && rsp_len != 8'h00) begin
          if (rsp_wait != 4'h0) begin
            rsp_wait <= rsp_wait - 4'h1;
          end else begin
            rsp_sr <= {rsp_sr[134:0], 1'b1};
            rsp_len <= rsp_len - 8'h01;
          end
        end
        // Block fully received: hand the sector to the back end
        if (card_st == `CSM_ST_RCV && dst == D_OFF && !cmd_done) begin
          card_st <= `CSM_ST_PRG;
          op_req_o <= 1'b1;
          op_wr_o <= 1'b1;
        end
        if (op_done_i && card_st == `CSM_ST_DATA) begin
          card_st <= `CSM_ST_TRAN;
        end
        if (op_done_i && card_st == `CSM_ST_PRG && !verifying) begin
          if (no_erase) begin
            card_st <= `CSM_ST_TRAN;
          end else begin
            verifying <= 1'b1;
            verify_req_o <= 1'b1;
          end
        end
        if (verify_done_i && verifying) begin
          verifying <= 1'b0;
          card_st <= `CSM_ST_TRAN;
          remap_req_o <= verify_fail_i;
        end
      end
    end
  end

  // Response drive on falling bus clock edges; low enable drives the line
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      cmd_o <= 1'b1;
      cmd_oe_n_o <= 1'b1;
    end else if (link_fall) begin
      if (rsp_len != 8'h00 && rsp_wait == 4'h0) begin
        cmd_o <= rsp_sr[135];
        cmd_oe_n_o <= 1'b0;
      end else begin
        cmd_o <= 1'b1;
        cmd_oe_n_o <= 1'b1;
      end
    end
  end

  // Write data on DAT0: start bit, 512 bytes, CRC-16, end bit
  // Only the one-line layout is checked; wider buses need one lane per line
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      dst <= D_OFF;
      dcnt <= 13'h0;
      dcrc <= 16'h0;
      dcrc_rx <= 16'h0;
      wr_data_o <= 8'h00;
      wr_stb_o <= 1'b0;
      blk_crc_err_o <= 1'b0;
      data_err <= 1'b0;
    end else begin
      wr_stb_o <= 1'b0;
      blk_crc_err_o <= 1'b0;
      data_err <= 1'b0;
      if (cmd_done && next_st == `CSM_ST_RCV && card_st == `CSM_ST_TRAN) begin
        dst <= D_START;
      end else if (link_rise) begin
        case (dst)
          D_START: begin
            if (!dat_lvl) begin
              dst <= D_BITS;
              dcnt <= 13'h0;
              dcrc <= 16'h0;
            end
          end
          D_BITS: begin
            dcrc <= dcrc_nx;
            wr_data_o <= {wr_data_o[6:0], dat_lvl};
            wr_stb_o <= (dcnt[2:0] == 3'h7);
            if (dcnt == `CSM_SECT_BITS - 13'h1) begin
              dst <= D_CRC;
              dcnt <= 13'h0;
            end else begin
              dcnt <= dcnt + 13'h1;
            end
          end
          D_CRC: begin
            dcrc_rx <= {dcrc_rx[14:0], dat_lvl};
            if (dcnt == 13'h10) begin
              dst <= D_OFF;
              blk_crc_err_o <= (dcrc_rx != dcrc) || !dat_lvl;
              data_err <= (dcrc_rx != dcrc) || !dat_lvl;
            end else begin
              dcnt <= dcnt + 13'h1;
            end
          end
          default: begin
            dst <= D_OFF;
          end
        endcase
      end
    end
  end

  // Idle timer on the core clock; a start bit wakes the card at once
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      idle_cnt <= {SW{1'b0}};
      asleep_o <= 1'b0;
    end else if (rx_busy || cmd_done || op_done_i || verify_done_i) begin
      idle_cnt <= {SW{1'b0}};
      asleep_o <= 1'b0;
    end else if (card_st == `CSM_ST_PRG || card_st == `CSM_ST_DATA ||
                 card_st == `CSM_ST_RCV || rsp_len != 8'h00 || !cmd_oe_n_o) begin
      // The line is busy until the end bit has left the pin
      idle_cnt <= {SW{1'b0}};
    end else if (idle_cnt == SLEEP_END) begin
      asleep_o <= 1'b1;
    end else begin
      idle_cnt <= idle_cnt + {{(SW-1){1'b0}}, 1'b1};
    end
  end

  // Card data register: fixed 512-byte blocks, group sizes, speed class
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      card_specific_data_reg_o <= 128'h0;
      card_specific_data_reg_o[`CSM_CSD_SPEED +: 8] <= SPEED_CODE;
      card_specific_data_reg_o[`CSM_CSD_BLEN +: 4] <= `CSM_BLEN_CODE;
      card_specific_data_reg_o[`CSM_CSD_BPROG] <= 1'b0;
      card_specific_data_reg_o[`CSM_CSD_ERGRP +: 5] <= ERASE_GRP;
      card_specific_data_reg_o[`CSM_CSD_WPGRP +: 5] <= WP_GRP;
      card_specific_data_reg_o[0] <= 1'b1;
    end
  end
endmodule

// >>> rtl/csm_consts.vh
`ifndef CSM_CONSTS_VH
`define CSM_CONSTS_VH
// Function
// - Sleep after 5 ms without commands
// - Any command wakes card, answered normally
// - Unsupported voltage window makes card inactive
// - Inactive lasts until power cycle
// - Go-inactive command makes card inactive
// - Hold 32-bit status, send in responses
// - Status shows state and completion codes
// - Status-poll command returns current status
// - Bus widths 1, 4, 8; 1 after reset
// - Any bus clock up to class limit
// - Byte is smallest unit, blocks whole bytes
// - Block sizes published in card data register
// - Erase group size published in card data
// - Protect group in erase groups, published
// - 512-byte sectors, start address and count
// - Verify after write unless no-erase write
// - Defective bit remaps whole sector to spare
// - ECC recovery substitutes spare bits
// - Data blocks carry checked 16-bit CRC

// Timing
`define CSM_SLEEP_MS 5
`define CSM_CLK_KHZ 250000
`define CSM_SLEEP_CYC (`CSM_SLEEP_MS * `CSM_CLK_KHZ)
`define CSM_NCR 4'h2

// Command indices
`define CSM_CMD_RESET 6'h00
`define CSM_CMD_OPCOND 6'h01
`define CSM_CMD_SWITCH 6'h06
`define CSM_CMD_SELECT 6'h07
`define CSM_CMD_RDCSD 6'h09
`define CSM_CMD_STATUS 6'h0d
`define CSM_CMD_INACT 6'h0f
`define CSM_CMD_BLKLEN 6'h10
`define CSM_CMD_RD 6'h11
`define CSM_CMD_SECCNT 6'h17
`define CSM_CMD_WR 6'h18
`define CSM_CMD_WRNE 6'h3c

// Card states as reported in the status word
`define CSM_ST_IDLE 4'h0
`define CSM_ST_READY 4'h1
`define CSM_ST_TRAN 4'h4
`define CSM_ST_DATA 4'h5
`define CSM_ST_RCV 4'h6
`define CSM_ST_PRG 4'h7

// Status word bit positions
`define CSM_SB_OOR 31
`define CSM_SB_BLKLEN 29
`define CSM_SB_CRC 23
`define CSM_SB_ILL 22
`define CSM_SB_ERR 19
`define CSM_SB_RDY 8
`define CSM_SB_SWERR 7

// Sector and CRC
`define CSM_SECT_BYTES 32'h00000200
`define CSM_SECT_BITS 13'h1000
`define CSM_BLEN_CODE 4'h9
`define CSM_CRC7_POLY 7'h09
`define CSM_CRC16_POLY 16'h1021

// Card data register field positions
`define CSM_CSD_SPEED 96
`define CSM_CSD_BLEN 80
`define CSM_CSD_BPROG 79
`define CSM_CSD_ERGRP 42
`define CSM_CSD_WPGRP 32
`endif

// >>> rtl/csm_sync.v
`timescale 1ns/1ps
// Three-stage input synchroniser with agreement filter
module csm_sync #(
  parameter RST_VAL = 1'b1
) (
  // Clock and reset
  input wire clk_i,
  input wire sys_rst_i,
  // Pin side
  input wire async_i,
  // Filtered level
  output reg level_o
);
  reg s1;
  reg s2;
  reg s3;

  // The first stage feeds only the second, keeping metastability contained
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      s1 <= RST_VAL;
      s2 <= RST_VAL;
      s3 <= RST_VAL;
      level_o <= RST_VAL;
    end else begin
      s1 <= async_i;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        level_o <= s3;
      end
    end
  end
endmodule

// >>> verif/csm_host_model.sv
`timescale 1ns/1ps
// Host side of the card bus: link clock, command frames, reply capture
module csm_host_model (
  // Card outputs
  input wire cmd_o,
  input wire cmd_oe_n_o,
  // Bus pins
  output reg link_clk_o,
  output wire cmd_w_o
);
  reg drv = 1'b1;
  // Line has a pull-up, so a released line reads high
  assign cmd_w_o = drv & (cmd_oe_n_o | cmd_o);
  // Clock stands low between frames
  initial link_clk_o = 1'b0;
  // Frame check code over the leading 40 bits
  function [6:0] crc7(input [39:0] d);
    integer k;
    reg fb;
    begin
      crc7 = 7'h00;
      for (k = 39; k >= 0; k = k - 1) begin
        fb = d[k] ^ crc7[6];
        crc7 = {crc7[5:0], 1'b0} ^ (fb ? 7'h09 : 7'h00);
      end
    end
  endfunction
  // Send one frame, then clock 90 more bus cycles, keeping the first 48 reply bits
  task cmd(input [5:0] idx, input [31:0] arg, input bad, output [47:0] rsp, output got);
    reg [47:0] fr;
    integer i;
    integer n;
    begin
      fr = {2'b01, idx, arg, crc7({2'b01, idx, arg}) ^ {6'h00, bad}, 1'b1};
      for (i = 47; i >= 0; i = i - 1) begin
        drv = fr[i];
        #16 link_clk_o = 1'b1;
        #16 link_clk_o = 1'b0;
      end
      drv = 1'b1;
      rsp = 48'h0;
      n = 0;
      // Sample late in the bit, well after the card's sync delay
      for (i = 0; i < 90; i = i + 1) begin
        #16 link_clk_o = 1'b1;
        #15 if (n < 48 && (n > 0 || !cmd_w_o)) begin
          rsp = {rsp[46:0], cmd_w_o};
          n = n + 1;
        end
        #1 link_clk_o = 1'b0;
      end
      got = (n == 48);
    end
  endtask
endmodule

// >>> verif/csm_card_state_props.sv
`timescale 1ns/1ps
// Port-level checks of the card state block
module csm_card_state_props #(
  parameter SLEEP_CYC = 200
) (
  // Clock and reset
  input wire clk_i,
  input wire sys_rst_i,
  // Watched signals
  input wire cmd_i,
  input wire cmd_o,
  input wire cmd_oe_n_o,
  input wire op_done_i,
  input wire verify_done_i,
  input wire verify_fail_i,
  input wire ecc_fix_i,
  input wire remap_req_o,
  input wire spare_sub_o,
  input wire asleep_o,
  input wire inactive_o,
  input wire [1:0] bus_width_o,
  input wire [31:0] status_o
);
  reg [15:0] quiet;
  // Cycles since the last bus or back-end activity; the card sees it later
  always @(posedge clk_i) begin
    if (sys_rst_i || !cmd_i || !cmd_oe_n_o || op_done_i || status_o[12:9] == 4'h5 ||
        status_o[12:9] == 4'h6 || status_o[12:9] == 4'h7)
      quiet <= 16'h0000;
    else if (quiet != 16'hffff)
      quiet <= quiet + 16'h0001;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  inact_quiet_a: assert property (inactive_o |-> cmd_oe_n_o)
    else $error("line driven while inactive");
  inact_hold_a: assert property (inactive_o |=> inactive_o)
    else $error("inactive state left");
  resp_frame_a: assert property ($fell(cmd_oe_n_o) |-> !cmd_o ##1 (!cmd_oe_n_o)[*8])
    else $error("reply frame malformed");
  state_code_a: assert property (status_o[12:9] inside {4'h0, 4'h1, 4'h4, 4'h5, 4'h6, 4'h7})
    else $error("bad state code");
  ready_bit_a: assert property (status_o[8] == (status_o[12:9] == 4'h4))
    else $error("ready bit wrong");
  width_code_a: assert property (bus_width_o != 2'h3)
    else $error("bad width code");
  sleep_early_a: assert property ($rose(asleep_o) |-> quiet >= SLEEP_CYC)
    else $error("slept too early");
  sleep_late_a: assert property (quiet == SLEEP_CYC + 40 && !inactive_o |-> asleep_o)
    else $error("did not sleep");
  wake_up_a: assert property (asleep_o && !cmd_i && !inactive_o |-> ##[1:20] !asleep_o)
    else $error("did not wake");
  spare_sub_a: assert property (ecc_fix_i |=> spare_sub_o)
    else $error("no spare substitution");
  remap_sect_a: assert property (remap_req_o |-> $past(verify_done_i) && $past(verify_fail_i))
    else $error("remap without failed verify");
endmodule
bind csm_card_state csm_card_state_props #(.SLEEP_CYC(SLEEP_CYC)) u_props (.clk_i, .sys_rst_i,
  .cmd_i, .cmd_o, .cmd_oe_n_o, .op_done_i, .verify_done_i, .verify_fail_i, .ecc_fix_i,
  .remap_req_o, .spare_sub_o, .asleep_o, .inactive_o, .bus_width_o, .status_o);

// >>> verif/tb_card_state_status_manager.sv
`timescale 1ns/1ps
module tb_card_state_status_manager;
  reg clk_i = 1'b0;
  reg sys_rst_i = 1'b1;
  reg op_done_i = 1'b0;
  reg ecc_fix_i = 1'b0;
  wire link_clk, cmd_w, cmd_o, cmd_oe_n_o, op_req_o, op_wr_o, asleep_o, inactive_o;
  wire [31:0] op_addr_o;
  wire [31:0] status_o;
  wire [1:0] bus_width_o;
  wire [127:0] card_specific_data_reg;
  integer num_errors = 0;
  integer cmp_count = 0;
  integer seed = 31;
  integer i;
  reg [47:0] r;
  reg g;
  reg [31:0] a;
  reg [32:0] seen;
  integer awake_cnt = 0;
  // Short idle threshold keeps the sleep case brief
  csm_card_state #(.SLEEP_CYC(200)) dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .link_clk_i(link_clk), .cmd_i(cmd_w), .dat0_i(1'b1), .cmd_o(cmd_o),
    .cmd_oe_n_o(cmd_oe_n_o), .op_done_i(op_done_i), .verify_done_i(1'b0),
    .verify_fail_i(1'b0), .ecc_fix_i(ecc_fix_i), .op_req_o(op_req_o), .op_wr_o(op_wr_o),
    .op_addr_o(op_addr_o), .sec_cnt_o(), .wr_data_o(), .wr_stb_o(), .verify_req_o(),
    .remap_req_o(), .spare_sub_o(), .asleep_o(asleep_o), .inactive_o(inactive_o),
    .bus_width_o(bus_width_o), .status_o(status_o), .blk_crc_err_o(),
    .card_specific_data_reg_o(card_specific_data_reg));
  csm_host_model h (.cmd_o(cmd_o), .cmd_oe_n_o(cmd_oe_n_o), .link_clk_o(link_clk),
    .cmd_w_o(cmd_w));
  // Core clock, 4 ns
  initial forever #2 clk_i = ~clk_i;
  // Back-end start is a one-cycle pulse, so latch what it carried
  always @(posedge clk_i) begin
    if (op_req_o)
      seen <= {op_wr_o, op_addr_o};
  end
  // Awake cycles; the card may fall asleep again before a reply check
  always @(posedge clk_i) begin
    if (!asleep_o)
      awake_cnt <= awake_cnt + 1;
  end
  task chk(input [47:0] got, input [47:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task report_and_stop;
    begin
      $display("errors=%0d compares=%0d", num_errors, cmp_count);
      if (num_errors == 0 && cmp_count > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  task wt(input integer n);
    repeat (n) @(posedge clk_i);
  endtask
  // Reset stands for a power cycle
  task rst;
    begin
      @(posedge clk_i) sys_rst_i <= 1'b1;
      wt(20);
      sys_rst_i <= 1'b0;
      wt(8);
    end
  endtask
  // Cut a hang short
  initial begin
    #360000;
    num_errors = num_errors + 1;
    report_and_stop;
  end
  // Main sequence
  initial begin
    rst;
    chk({bus_width_o, status_o[12:9]}, 6'h00);
    chk({card_specific_data_reg[103:96], card_specific_data_reg[83:79]}, {8'h32, 4'h9, 1'b0});
    chk({card_specific_data_reg[46:42], card_specific_data_reg[36:32], card_specific_data_reg[0]}, {5'h1f, 5'h03, 1'b1});
    h.cmd(6'h0d, 32'h0, 1'b0, r, g);
    chk(g, 1'b0);
    h.cmd(6'h01, 32'h00ff8000, 1'b0, r, g);
    chk({g, r[45:0]}, {1'b1, 6'h3f, 1'b1, 31'h00ff8000, 8'hff});
    chk(status_o[12:9], 4'h1);
    h.cmd(6'h07, 32'h0, 1'b0, r, g);
    chk({g, status_o[12:8]}, {1'b1, 4'h4, 1'b1});
    // Corrupt frame is dropped, and its flag shows in the next reply only
    h.cmd(6'h0d, 32'h0, 1'b1, r, g);
    chk(g, 1'b0);
    h.cmd(6'h0d, 32'h0, 1'b0, r, g);
    chk({g, r[45:40], r[31], r[20:17]}, {1'b1, 6'h0d, 1'b1, 4'h4});
    h.cmd(6'h0d, 32'h0, 1'b0, r, g);
    chk(r[31], 1'b0);
    // Widths 1, 4, 8 apply; an undefined code is refused
    for (i = 0; i < 4; i = i + 1) begin
      h.cmd(6'h06, i << 8, 1'b0, r, g);
      chk({r[15], bus_width_o}, (i == 3) ? 3'h6 : i);
    end
    a = {$random(seed)} % 512;
    h.cmd(6'h10, a, 1'b0, r, g);
    chk(r[37], 1'b1);
    h.cmd(6'h10, 32'h00000200, 1'b0, r, g);
    chk(r[37], 1'b0);
    a = $random(seed) << 9;
    h.cmd(6'h11, a, 1'b0, r, g);
    chk({seen, status_o[12:9]}, {1'b0, a, 4'h5});
    @(posedge clk_i) op_done_i <= 1'b1;
    @(posedge clk_i) op_done_i <= 1'b0;
    // Random corrected-read events
    for (i = 0; i < 12; i = i + 1)
      @(posedge clk_i) ecc_fix_i <= $random(seed);
    @(posedge clk_i) ecc_fix_i <= 1'b0;
    wt(4);
    chk(status_o[12:9], 4'h4);
    wt(150);
    chk(asleep_o, 1'b0);
    wt(120);
    chk(asleep_o, 1'b1);
    a = awake_cnt;
    h.cmd(6'h0d, 32'h0, 1'b0, r, g);
    chk({g, r[45:40], awake_cnt == a}, {1'b1, 6'h0d, 1'b0});
    h.cmd(6'h0f, 32'h0, 1'b0, r, g);
    chk({g, inactive_o}, 2'h1);
    h.cmd(6'h0d, 32'h0, 1'b0, r, g);
    h.cmd(6'h00, 32'h0, 1'b0, r, g);
    chk({g, inactive_o}, 2'h1);
    rst;
    chk(inactive_o, 1'b0);
    h.cmd(6'h01, 32'h00007fff, 1'b0, r, g);
    chk({g, inactive_o}, 2'h1);
    report_and_stop;
  end
endmodule
